// ===== hdl/crsm_core_map.v
// Core reset state, memory map, stack pointers and shared port pins
// How it works
// - Program counter restarts at 0110H
// - Reset clears interrupt and prefix flags
// - Data, index, stack registers undefined
// - Interrupts masked until both stacks written
// - Rewriting one stack pointer remasks interrupts
// - Prefix write sets flag for next instruction
// - Output bits reset as high outputs
// - I/O pins reset as inputs
// - Alternate pin functions follow software selection
// - Program ROM 4096 13-bit steps
// - Interrupt vectors at 0100H, 0104H-010EH
// - RAM 1024 nibbles at 0000H-03FFH
// - Wide access only at 0100H-01FFH
// - Stack pointers wrap in their ranges
// - Any aligned wide access in the window does 16-bit access, stack or not
// - Call pushes 4, interrupt 4 plus 1
// - Data ROM 2048 nibbles at 8000H-87FFH
// - Peripherals reached through memory-mapped I/O
// - Sleep opcode not implemented
`timescale 1ns/1ps
`include "crsm_regs.vh"
module crsm_core_map
(
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst_n,
	// Program fetch
	input  wire        i_fetch,
	input  wire        i_jump,
	input  wire [15:0] i_jump_addr,
	output reg  [15:0] o_pc,
	output reg  [12:0] o_instr,
	output reg         o_prog_ok,
	// Program ROM load port
	input  wire        i_prom_wr,
	input  wire [11:0] i_prom_addr,
	input  wire [12:0] i_prom_data,
	// Data memory access
	input  wire [15:0] i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire        i_wide,
	output reg  [15:0] o_rdata,
	output reg         o_wide_err,
	// Peripheral I/O window
	output reg         o_io_wr,
	output reg         o_io_rd,
	output reg  [7:0]  o_io_addr,
	output reg  [3:0]  o_io_wdata,
	input  wire [3:0]  i_io_rdata,
	// Core registers
	input  wire        i_prefix_wr,
	input  wire [7:0]  i_prefix_data,
	input  wire        i_instr_done,
	input  wire        i_int_flag_set,
	input  wire        i_int_flag_clr,
	input  wire        i_wide_sp_wr,
	input  wire        i_nib_sp_wr,
	input  wire [15:0] i_sp_data,
	input  wire        i_call,
	input  wire        i_int_entry,
	output reg         o_prefix_active,
	output reg  [7:0]  o_address_prefix_register,
	output reg         o_int_flag,
	output reg         o_int_mask,
	output reg  [15:0] o_wide_stack_pointer,
	output reg  [7:0]  o_nibble_stack_pointer,
	// Interrupt requests
	input  wire        i_nmi_req,
	input  wire [5:0]  i_hwi_req,
	output reg         o_int_take,
	output reg  [15:0] o_int_vector,
	// Pin function selection
	input  wire        i_timer_sel,
	input  wire        i_clock_sel,
	input  wire        i_serial_en,
	input  wire        i_serial_slave,
	input  wire        i_pullup_opt,
	input  wire [3:0]  i_out_data,
	input  wire [7:0]  i_io_dir,
	input  wire [7:0]  i_io_out,
	input  wire        i_timer_pin_output,
	input  wire        i_clock_pin_output,
	input  wire        i_serial_data_out,
	input  wire        i_sclk_out,
	input  wire        i_serial_ready_output,
	input  wire [3:0]  i_io_port0_bits,
	input  wire [3:0]  i_io_port1_bits,
	output reg  [3:0]  o_output_port_bits,
	output reg  [7:0]  o_io_pins,
	output reg  [7:0]  o_io_pins_oe_n,
	output reg  [7:0]  o_io_pullup,
	output reg         o_serial_data_in,
	output reg         o_sclk_in
);
	// ------------------------------------------------------------
	// Memories
	// ------------------------------------------------------------
	reg  [12:0] prog_rom [0:4095];
	reg  [3:0]  data_rom [0:2047];

	wire hit_ram  = (i_addr <= `CRSM_RAM_LAST);
	wire hit_wide = (i_addr >= `CRSM_WIDE_FIRST) && (i_addr <= `CRSM_WIDE_LAST);
	wire hit_drom = (i_addr >= `CRSM_DROM_FIRST) && (i_addr <= `CRSM_DROM_LAST);
	wire hit_io   = (i_addr >= `CRSM_IO_FIRST);
	wire wide_ok  = hit_wide && (i_addr[1:0] == 2'h0);
	wire [9:0]  ram_ix  = i_addr[9:0];
	wire [10:0] drom_ix = i_addr[10:0];
	wire [11:0] pc_ix   = o_pc[11:0];
	wire pc_in_rom = (o_pc <= `CRSM_PROG_LAST);

	// ------------------------------------------------------------
	// Program counter and fetch
	// ------------------------------------------------------------
	// Sleep opcode is treated as an ordinary fetch; no halt logic exists
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_pc      <= `CRSM_PC_RESET;
			o_instr   <= 13'h0000;
			o_prog_ok <= 1'b0;
		end
		else
		begin
			if (o_int_take)
				o_pc <= o_int_vector;
			else if (i_jump)
				o_pc <= i_jump_addr;
			else if (i_fetch)
				o_pc <= o_pc + 16'h0001;
			if (i_fetch)
			begin
				o_instr   <= pc_in_rom ? prog_rom[pc_ix] : 13'h0000;
				o_prog_ok <= pc_in_rom;
			end
		end
	end

	always @(posedge i_clk)
	begin
		if (i_prom_wr)
			prog_rom[i_prom_addr] <= i_prom_data;
	end

	// ------------------------------------------------------------
	// Data memory
	// ------------------------------------------------------------
	// Memory arrays carry no reset, so their contents start undefined
	// Four nibble lanes, one writer each, so a wide access reaches all at once
	wire [15:0] lane_q;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_lane
			localparam [1:0] LANE = g;
			reg  [3:0] lane_mem [0:255];
			wire       wide_go = i_wide && wide_ok;
			wire       lane_we = i_wr && hit_ram && (wide_go || (ram_ix[1:0] == LANE));
			wire [3:0] lane_wd = wide_go ? i_wdata[4*g+3:4*g] : i_wdata[3:0];
			always @(posedge i_clk)
			begin
				if (lane_we)
					lane_mem[ram_ix[9:2]] <= lane_wd;
			end
			assign lane_q[4*g+3:4*g] = lane_mem[ram_ix[9:2]];
		end
	endgenerate

	// Data ROM is written only through the initial load port alias
	always @(posedge i_clk)
	begin
		if (i_prom_wr && i_prom_addr[11])
			data_rom[i_prom_addr[10:0]] <= i_prom_data[3:0];
	end

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rdata    <= 16'h0000;
			o_wide_err <= 1'b0;
			o_io_wr    <= 1'b0;
			o_io_rd    <= 1'b0;
			o_io_addr  <= 8'h00;
			o_io_wdata <= 4'h0;
		end
		else
		begin
			o_io_wr    <= i_wr && hit_io;
			o_io_rd    <= i_rd && hit_io;
			o_io_addr  <= i_addr[7:0];
			o_io_wdata <= i_wdata[3:0];
			// Wide access outside the wide window or not aligned to four nibbles raises o_wide_err and is done as a one-nibble access
			o_wide_err <= (i_wr || i_rd) && i_wide && !wide_ok;
			if (i_rd)
			begin
				if (hit_ram && i_wide && wide_ok)
					o_rdata <= lane_q;
				else if (hit_ram)
					o_rdata <= {12'h000, lane_q[{ram_ix[1:0], 2'h0} +: 4]};
				else if (hit_drom)
					o_rdata <= {12'h000, data_rom[drom_ix]};
				else if (hit_io)
					o_rdata <= {12'h000, i_io_rdata};
				else
					o_rdata <= {12'h000, `CRSM_UNDEF_DATA};
			end
		end
	end

	// ------------------------------------------------------------
	// Core flags and prefix
	// ------------------------------------------------------------
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_prefix_active <= 1'b0;
			o_int_flag      <= 1'b0;
		end
		else
		begin
			// Prefix holds for exactly one following instruction
			if (i_prefix_wr)
				o_prefix_active <= 1'b1;
			else if (i_instr_done)
				o_prefix_active <= 1'b0;
			if (i_int_flag_set)
				o_int_flag <= 1'b1;
			else if (i_int_flag_clr || o_int_take)
				o_int_flag <= 1'b0;
		end
	end

	// Data registers and pointers take no reset value
	always @(posedge i_clk)
	begin
		if (i_prefix_wr)
			o_address_prefix_register <= i_prefix_data;
		if (i_wide_sp_wr)
			o_wide_stack_pointer <= i_sp_data & `CRSM_SPW_MASK;
		else if (i_call || i_int_entry)
			o_wide_stack_pointer <= (o_wide_stack_pointer
				- {13'h0000, `CRSM_CALL_WORDS}) & `CRSM_SPW_MASK;
		if (i_nib_sp_wr)
			o_nibble_stack_pointer <= i_sp_data[7:0];
		else if (i_int_entry)
			o_nibble_stack_pointer <= o_nibble_stack_pointer - 8'h01;
	end

	// ------------------------------------------------------------
	// Interrupt masking and vectors
	// ------------------------------------------------------------
	wire guard_mask;
	crsm_stack_guard u_guard
	(
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_wide_sp_wr (i_wide_sp_wr),
		.i_nib_sp_wr  (i_nib_sp_wr),
		.o_int_mask   (guard_mask)
	);

	reg [15:0] next_vector;
	reg        next_take;
	integer    k;
	always @*
	begin
		next_vector = `CRSM_NMI_VECTOR;
		next_take   = 1'b0;
		for (k = 5; k >= 0; k = k - 1)
		begin
			if (i_hwi_req[k] && o_int_flag)
			begin
				next_take   = 1'b1;
				next_vector = `CRSM_HWI_VEC_FIRST + {k[14:0], 1'b0};
			end
		end
		if (i_nmi_req)
		begin
			next_take   = 1'b1;
			next_vector = `CRSM_NMI_VECTOR;
		end
		// Both mask copies gate, so no take slips out while the output shows masked
		if (guard_mask || o_int_mask || o_int_take)
			next_take = 1'b0;
	end

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_int_mask   <= 1'b1;
			o_int_take   <= 1'b0;
			o_int_vector <= `CRSM_NMI_VECTOR;
		end
		else
		begin
			o_int_mask   <= guard_mask;
			o_int_take   <= next_take;
			o_int_vector <= next_vector;
		end
	end

	// ------------------------------------------------------------
	// Shared pins
	// ------------------------------------------------------------
	reg [3:0] next_out;
	reg [7:0] next_pins;
	reg [7:0] next_oe_n;
	always @*
	begin
		next_out  = i_out_data;
		next_pins = i_io_out;
		next_oe_n = ~i_io_dir;
		if (i_timer_sel)
			next_out[2] = i_timer_pin_output;
		if (i_clock_sel)
			next_out[3] = i_clock_pin_output;
		if (i_serial_en)
		begin
			next_oe_n[4] = 1'b1;
			next_pins[5] = i_serial_data_out;
			next_oe_n[5] = 1'b0;
			next_pins[6] = i_sclk_out;
			next_oe_n[6] = i_serial_slave;
			next_pins[7] = i_serial_ready_output;
			next_oe_n[7] = !i_serial_slave;
		end
	end

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_output_port_bits <= `CRSM_OUT_RESET;
			o_io_pins          <= 8'h00;
			o_io_pins_oe_n     <= 8'hFF;
			o_io_pullup        <= 8'h00;
			o_serial_data_in   <= 1'b0;
			o_sclk_in          <= 1'b0;
		end
		else
		begin
			o_output_port_bits <= next_out;
			o_io_pins          <= next_pins;
			o_io_pins_oe_n     <= next_oe_n;
			o_io_pullup        <= i_pullup_opt ? next_oe_n : 8'h00;
			o_serial_data_in   <= i_io_port1_bits[0];
			o_sclk_in          <= i_io_port1_bits[2];
		end
	end
endmodule // crsm_core_map

// ===== hdl/crsm_regs.vh
// Constants of the core reset state and memory map block
`ifndef CRSM_REGS_VH
`define CRSM_REGS_VH
`define CRSM_PC_RESET      16'h0110
`define CRSM_NMI_VECTOR    16'h0100
`define CRSM_HWI_VEC_FIRST 16'h0104
`define CRSM_HWI_VEC_LAST  16'h010E
`define CRSM_PROG_LAST     16'h0FFF
`define CRSM_RAM_FIRST     16'h0000
`define CRSM_RAM_LAST      16'h03FF
`define CRSM_WIDE_FIRST    16'h0100
`define CRSM_WIDE_LAST     16'h01FF
`define CRSM_DROM_FIRST    16'h8000
`define CRSM_DROM_LAST     16'h87FF
`define CRSM_IO_FIRST      16'hFF00
`define CRSM_IO_LAST       16'hFFFF
`define CRSM_SPW_MASK      16'h03FF
`define CRSM_SPN_MASK      16'h00FF
`define CRSM_CALL_WORDS    3'h4
`define CRSM_INT_WORDS     3'h5
`define CRSM_OUT_RESET     4'hF
`define CRSM_UNDEF_DATA    4'h0
`endif

// ===== hdl/crsm_stack_guard.v
// Stack pointer pairing guard that masks interrupts
`timescale 1ns/1ps
module crsm_stack_guard
(
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst_n,
	// Stack pointer writes
	input  wire        i_wide_sp_wr,
	input  wire        i_nib_sp_wr,
	// Mask state
	output reg         o_int_mask
);
	reg wide_set;
	reg nib_set;
	reg next_wide_set;
	reg next_nib_set;

	always @*
	begin
		next_wide_set = wide_set;
		next_nib_set  = nib_set;
		if (i_wide_sp_wr && i_nib_sp_wr)
		begin
			next_wide_set = 1'b1;
			next_nib_set  = 1'b1;
		end
		else if (i_wide_sp_wr)
		begin
			// Rewriting one of a set pair drops the other until it follows
			next_wide_set = 1'b1;
			if (wide_set && nib_set)
				next_nib_set = 1'b0;
		end
		else if (i_nib_sp_wr)
		begin
			next_nib_set = 1'b1;
			if (wide_set && nib_set)
				next_wide_set = 1'b0;
		end
	end

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wide_set   <= 1'b0;
			nib_set    <= 1'b0;
			o_int_mask <= 1'b1;
		end
		else
		begin
			wide_set   <= next_wide_set;
			nib_set    <= next_nib_set;
			o_int_mask <= !(next_wide_set && next_nib_set);
		end
	end
endmodule // crsm_stack_guard

// ===== verif/crsm_core_map_monitor.sv
// Concurrent checks on the core reset state and memory map block
`timescale 1ns/1ps
module crsm_core_map_monitor
(
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	// Stimulus seen
	input wire logic        i_wr,
	input wire logic        i_wide,
	input wire logic [15:0] i_addr,
	input wire logic        i_prefix_wr,
	input wire logic [7:0]  i_prefix_data,
	input wire logic        i_wide_sp_wr,
	input wire logic        i_nib_sp_wr,
	input wire logic        i_call,
	input wire logic        i_int_entry,
	input wire logic        i_nmi_req,
	// Outputs watched
	input wire logic [15:0] o_pc,
	input wire logic        o_wide_err,
	input wire logic        o_io_wr,
	input wire logic        o_prefix_active,
	input wire logic [7:0]  o_address_prefix_register,
	input wire logic        o_int_flag,
	input wire logic        o_int_mask,
	input wire logic [15:0] o_wide_stack_pointer,
	input wire logic [7:0]  o_nibble_stack_pointer,
	input wire logic        o_int_take,
	input wire logic [15:0] o_int_vector,
	input wire logic [3:0]  o_output_port_bits,
	input wire logic [7:0]  o_io_pins_oe_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_pc_start: assert property ($rose(i_rst_n) |-> o_pc == 16'h0110)
		else $error("pc not at start step after reset");
	a_flags_clear: assert property ($rose(i_rst_n) |-> !o_int_flag && !o_prefix_active)
		else $error("flags not cleared after reset");
	a_mask_reset: assert property ($rose(i_rst_n) |-> o_int_mask)
		else $error("interrupts not masked after reset");
	a_pins_reset: assert property ($rose(i_rst_n) |-> o_output_port_bits == 4'hF && o_io_pins_oe_n == 8'hFF)
		else $error("pin reset state wrong");
	// Masked for two cycles means no take may follow
	a_mask_blocks: assert property (o_int_mask [*2] |=> !o_int_take)
		else $error("interrupt taken while masked");
	a_remask_single: assert property (i_wide_sp_wr && !i_nib_sp_wr && !o_int_mask |-> ##[1:2] o_int_mask)
		else $error("single stack rewrite did not remask");
	a_prefix_set: assert property (i_prefix_wr |=> o_prefix_active && o_address_prefix_register == $past(i_prefix_data))
		else $error("prefix write did not set flag");
	a_call_push: assert property (i_call && !i_int_entry && !i_wide_sp_wr |=> o_wide_stack_pointer == (($past(o_wide_stack_pointer) - 16'h0004) & 16'h03FF))
		else $error("call push wrong");
	a_int_push: assert property (i_int_entry && !i_call && !i_nib_sp_wr |=> o_nibble_stack_pointer == $past(o_nibble_stack_pointer) - 8'h01)
		else $error("interrupt push wrong");
	a_wide_window: assert property (i_wr && i_wide && (i_addr < 16'h0100 || i_addr > 16'h01FC) |=> o_wide_err)
		else $error("wide access outside window not refused");
	a_nmi_vector: assert property (o_int_take && $past(i_nmi_req) |-> o_int_vector == 16'h0100)
		else $error("nmi vector wrong");
	a_io_window: assert property (i_wr && !i_wide && i_addr >= 16'hFF00 |=> o_io_wr)
		else $error("io write not forwarded");
	// ----------------------------------------
	// Covers
	// ----------------------------------------
	c_take: cover property (o_int_take);
	c_wide_err: cover property (o_wide_err);
	c_remask: cover property (!o_int_mask ##1 o_int_mask);
endmodule // crsm_core_map_monitor

bind crsm_core_map crsm_core_map_monitor u_mon (.*);

// ===== verif/crsm_core_map_test.sv
// Self-checking bench for the core reset state and memory map block
`timescale 1ns/1ps
module crsm_core_map_test;
	logic i_clk = 0, i_rst_n = 0, i_fetch = 0, i_jump = 0, i_prom_wr = 0, i_wr = 0, i_rd = 0;
	logic i_wide = 0, i_prefix_wr = 0, i_instr_done = 0, i_int_flag_set = 0, i_int_flag_clr = 0;
	logic i_wide_sp_wr = 0, i_nib_sp_wr = 0, i_call = 0, i_int_entry = 0, i_nmi_req = 0;
	logic i_timer_sel = 0, i_clock_sel = 0, i_serial_en = 0, i_serial_slave = 0, i_pullup_opt = 1;
	logic i_timer_pin_output = 0, i_clock_pin_output = 0, i_serial_data_out = 0, i_sclk_out = 0;
	logic i_serial_ready_output = 0;
	logic [15:0] i_jump_addr = 0, i_addr = 0, i_wdata = 0, i_sp_data = 0;
	logic [11:0] i_prom_addr = 0;
	logic [12:0] i_prom_data = 0, o_instr;
	logic [7:0] i_prefix_data = 0, i_io_dir = 0, i_io_out = 0;
	logic [5:0] i_hwi_req = 0;
	logic [3:0] i_io_rdata = 4'hA, i_out_data = 0, i_io_port0_bits = 0, i_io_port1_bits = 0;
	logic [3:0] e_out;
	logic [7:0] e_pins, e_oe;
	logic [15:0] o_pc, o_rdata, o_wide_stack_pointer, o_int_vector;
	logic o_prog_ok, o_wide_err, o_io_wr, o_io_rd, o_prefix_active, o_int_flag, o_int_mask;
	logic o_int_take, o_serial_data_in, o_sclk_in, rd_d;
	logic [7:0] o_io_addr, o_address_prefix_register, o_nibble_stack_pointer;
	logic [7:0] o_io_pins, o_io_pins_oe_n, o_io_pullup;
	logic [3:0] o_io_wdata, o_output_port_bits;
	logic [15:0] exp_q[$];
	logic [12:0] word;
	integer miscompares = 0, n_compared = 0, cycles = 0, seed = 32'h10ab0d00, k;

	crsm_core_map dut (.*);

	always #2 i_clk = ~i_clk;
	// ----------------------------------------
	// Checks and bus tasks
	// ----------------------------------------
	task report_and_stop;
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d, input logic w);
		@(posedge i_clk);
		i_addr <= a; i_wdata <= d; i_wide <= w; i_wr <= 1;
		@(posedge i_clk);
		i_wr <= 0; i_wide <= 0;
	endtask
	task rd(input logic [15:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge i_clk);
		i_addr <= a; i_rd <= 1;
		@(posedge i_clk);
		i_rd <= 0;
	endtask
	task wait_take;
		int n;
		n = 0;
		while (o_int_take !== 1'b1 && n < 20)
		begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 20)
			miscompares++;
	endtask
	// Read data appear in the cycle after the strobe and hold until the next read
	always @(posedge i_clk)
		rd_d <= i_rd;
	always @(negedge i_clk)
		if (rd_d === 1'b1)
			chk(o_rdata, exp_q.pop_front());
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles > 3000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1;
		@(negedge i_clk);
		chk(o_pc, 16'h0110);
		chk({o_int_flag, o_prefix_active, o_int_mask}, 16'h1);
		chk({o_output_port_bits, o_io_pins_oe_n}, 16'hFFF);
		word = $random(seed);
		@(posedge i_clk);
		i_prom_wr <= 1; i_prom_addr <= 12'h110; i_prom_data <= word;
		@(posedge i_clk);
		i_prom_addr <= 12'h805; i_prom_data <= 13'h0009;
		@(posedge i_clk);
		i_prom_wr <= 0; i_fetch <= 1;
		@(posedge i_clk);
		i_fetch <= 0;
		@(negedge i_clk);
		chk({2'h0, o_prog_ok, o_instr}, {3'h1, word});
		chk(o_pc, 16'h0111);
		@(posedge i_clk);
		i_jump <= 1; i_jump_addr <= 16'h1000;
		@(posedge i_clk);
		i_jump <= 0; i_fetch <= 1;
		@(posedge i_clk);
		i_fetch <= 0;
		@(negedge i_clk);
		chk({2'h0, o_prog_ok, o_instr}, 16'h0000);
		chk(o_pc, 16'h1001);
		for (k = 0; k < 4; k++)
		begin
			word = $random(seed);
			wr({6'h00, word[9:0]}, {12'h000, word[12:9]}, 0);
			rd({6'h00, word[9:0]}, {12'h000, word[12:9]});
		end
		rd(16'h8005, 16'h0009);
		rd(16'h5000, 16'h0000);
		wr(16'h0104, 16'h1234, 1);
		rd(16'h0107, 16'h0001);
		wr(16'h0200, 16'hABCD, 1);
		@(negedge i_clk);
		chk(o_wide_err, 1);
		wr(16'hFF21, 16'h0005, 0);
		@(negedge i_clk);
		chk({o_io_wr, o_io_addr, o_io_wdata}, 16'h1215);
		rd(16'hFF30, 16'h000A);
		@(negedge i_clk);
		chk({o_io_rd, o_io_addr}, 16'h0130);
		@(posedge i_clk);
		i_sp_data <= 16'h0002; i_wide_sp_wr <= 1;
		@(posedge i_clk);
		i_wide_sp_wr <= 0;
		repeat (3) @(negedge i_clk);
		chk(o_int_mask, 1);
		@(posedge i_clk);
		i_sp_data <= 16'h0000; i_nib_sp_wr <= 1;
		@(posedge i_clk);
		i_nib_sp_wr <= 0;
		repeat (3) @(negedge i_clk);
		chk(o_int_mask, 0);
		@(posedge i_clk);
		i_call <= 1;
		@(posedge i_clk);
		i_call <= 0; i_int_entry <= 1;
		@(posedge i_clk);
		i_int_entry <= 0;
		@(negedge i_clk);
		chk(o_wide_stack_pointer, 16'h03FA);
		chk(o_nibble_stack_pointer, 16'h00FF);
		@(posedge i_clk);
		i_nmi_req <= 1;
		wait_take();
		chk(o_int_vector, 16'h0100);
		@(posedge i_clk);
		i_nmi_req <= 0;
		for (k = 0; k < 6; k = k + 1)
		begin
			@(posedge i_clk);
			i_int_flag_set <= 1; i_hwi_req <= 6'h01 << k;
			@(posedge i_clk);
			i_int_flag_set <= 0;
			word = k;
			wait_take();
			chk(o_int_vector, 16'h0104 + 2 * word);
			@(posedge i_clk);
			i_hwi_req <= 0; i_int_flag_clr <= 1;
			@(posedge i_clk);
			i_int_flag_clr <= 0;
			repeat (3) @(posedge i_clk);
		end
		@(posedge i_clk);
		i_sp_data <= 16'h0150; i_wide_sp_wr <= 1;
		@(posedge i_clk);
		i_wide_sp_wr <= 0;
		repeat (3) @(negedge i_clk);
		chk(o_int_mask, 1);
		@(posedge i_clk);
		i_prefix_wr <= 1; i_prefix_data <= 8'hA5;
		@(posedge i_clk);
		i_prefix_wr <= 0;
		@(negedge i_clk);
		chk({o_prefix_active, o_address_prefix_register}, 16'h1A5);
		@(posedge i_clk);
		i_instr_done <= 1;
		@(posedge i_clk);
		i_instr_done <= 0;
		@(negedge i_clk);
		chk(o_prefix_active, 0);
		for (k = 0; k < 8; k++)
		begin
			@(posedge i_clk);
			{i_timer_sel, i_clock_sel, i_serial_en, i_serial_slave, i_out_data} <= $random(seed);
			{i_io_dir, i_io_out, i_io_port0_bits, i_io_port1_bits} <= $random(seed);
			{i_pullup_opt, i_timer_pin_output, i_clock_pin_output, i_serial_data_out, i_sclk_out,
				i_serial_ready_output} <= $random(seed);
			@(posedge i_clk);
			@(negedge i_clk);
			e_out = i_out_data;
			e_pins = i_io_out;
			e_oe = ~i_io_dir;
			if (i_timer_sel)
				e_out[2] = i_timer_pin_output;
			if (i_clock_sel)
				e_out[3] = i_clock_pin_output;
			// Serial in is input, data out drives, clock and ready follow the role
			if (i_serial_en)
			begin
				e_oe[7:4] = {!i_serial_slave, i_serial_slave, 2'b01};
				e_pins[7:5] = {i_serial_ready_output, i_sclk_out, i_serial_data_out};
			end
			chk(o_output_port_bits, e_out);
			chk({o_io_pins, o_io_pins_oe_n}, {e_pins, e_oe});
			chk(o_io_pullup, i_pullup_opt ? e_oe : 8'h00);
			chk({o_serial_data_in, o_sclk_in}, {i_io_port1_bits[0], i_io_port1_bits[2]});
		end
		report_and_stop();
	end
endmodule // crsm_core_map_test
